// file: lockin_output_lowpass_filter.v
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "lpf_map.vh"
module lockin_output_lowpass_filter
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Demodulated samples.
  input wire sample_valid,
  input wire signed [23:0] x_in,
  input wire signed [23:0] y_in,
  input wire signed [23:0] x_if_bypass,
  input wire signed [23:0] y_if_bypass,
  input wire [23:0] magnitude_in,
  // Filtered outputs.
  output reg signed [23:0] x_out,
  output reg signed [23:0] y_out,
  output reg xy_update,
  output reg rtheta_update,
  // Mode indications.
  output wire if_bypass,
  output wire tc_indicator_on,
  output reg output_filter_overflow_flag,
  output wire auto_active,
  output wire [4:0] sensitivity,
  // Interrupt.
  output wire irq
);
  reg [31:0] ctrl_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [4:0] sens_r;
  reg [9:0] div_r;
  reg [1:0] slow_r;
  reg fast_tick;
  reg slow_tick;
  reg signed [23:0] xd0, xd1, xd2, yd0, yd1, yd2;
  reg [1:0] auto_state_r;
  reg [13:0] auto_cnt_r;
  reg [6:0] tick_cnt_r;
  reg [39:0] tau_cnt_r;
  wire [4:0] tc_code;
  wire [2:0] slope;
  wire bypass;
  wire wr, mapped;
  wire [39:0] hund_cycles;
  wire [31:0] fast_div_w;
  wire hundredth;
  wire [13:0] settle_count;
  wire signed [23:0] xs [0:4];
  wire signed [23:0] ys [0:4];
  wire [7:0] ovf_v;
  wire [5:0] shift;
  wire step_en;
  wire settle_start, auto_req;
  wire ev_ovf, ev_done, ev_ref;
  reg signed [23:0] x_sel, y_sel;

  localparam AUTO_IDLE = 2'd0;
  localparam AUTO_WAIT = 2'd1;
  localparam AUTO_STEP = 2'd2;

  // Clock cycles per hundredth of the time constant; odd codes are 3x.
  // Forty bits keep the 30 ks setting from wrapping the count.
  function [39:0] tc_to_hundredth;
    input [4:0] code;
    reg [39:0] base;
    integer i;
    begin
      base = 40'h19;
      for (i = 0; i < 8; i = i + 1)
        if (i < code[4:1])
          base = base * 40'hA;
      tc_to_hundredth = code[0] ? base * 40'h3 : base;
    end
  endfunction

  // Limits a time constant code to the longest supported setting.
  function [4:0] clip_tc;
    input [4:0] code;
    begin
      clip_tc = (code > `TC_MAX_CODE) ? `TC_MAX_CODE : code;
    end
  endfunction

  // Shift that approximates sample period over time constant.
  function [5:0] tc_to_shift;
    input [4:0] code;
    begin
      tc_to_shift = 6'd3 + {1'b0, code} + {2'b00, code[4:1]};
    end
  endfunction

  assign tc_code = clip_tc(ctrl_r[`CTRL_TC_MSB:`CTRL_TC_LSB]);
  assign slope = ctrl_r[`CTRL_SLOPE_MSB:`CTRL_SLOPE_LSB];
  assign bypass = (slope >= `SLOPE_BYPASS);
  assign if_bypass = bypass;
  assign tc_indicator_on = !bypass;
  assign hund_cycles = tc_to_hundredth(tc_code);
  assign fast_div_w = `FAST_DIV - 1;
  assign shift = (tc_to_shift(tc_code) > 6'd23) ? 6'd23 :
                 tc_to_shift(tc_code);
  assign step_en = sample_valid;
  assign sensitivity = sens_r;

  // APB decode: zero wait states, error on unmapped addresses.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `REG_SENS);
  assign pslverr = psel && penable && !mapped;
  assign settle_start = wr && paddr == `REG_CTRL &&
                        pwdata[`CTRL_SETTLE_BIT];
  assign auto_req = wr && paddr == `REG_CTRL && pwdata[`CTRL_AUTO_BIT];

  // Cascade of four first-order stages.
  assign xs[0] = x_in;
  assign ys[0] = y_in;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : stage
      lpf_stage u_x (.pclk(pclk), .presetn(presetn), .step_en(step_en),
        .shift(shift), .din(xs[g]), .dout(xs[g+1]), .ovf(ovf_v[2*g]));
      lpf_stage u_y (.pclk(pclk), .presetn(presetn), .step_en(step_en),
        .shift(shift), .din(ys[g]), .dout(ys[g+1]), .ovf(ovf_v[2*g+1]));
    end
  endgenerate

  // Select the tap for the chosen number of stages or bypass.
  always @*
  begin
    x_sel = xs[0];
    y_sel = ys[0];
    if (bypass)
    begin
      x_sel = x_if_bypass;
      y_sel = y_if_bypass;
    end
    else
      case (slope)
        3'd1: begin x_sel = xs[1]; y_sel = ys[1]; end
        3'd2: begin x_sel = xs[2]; y_sel = ys[2]; end
        3'd3: begin x_sel = xs[3]; y_sel = ys[3]; end
        3'd4: begin x_sel = xs[4]; y_sel = ys[4]; end
        default: begin x_sel = xs[0]; y_sel = ys[0]; end
      endcase
  end

  // Fast and slow output rate enables.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r <= 10'd0;
      slow_r <= 2'd0;
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
    end
    else
    begin
      fast_tick <= (div_r == 10'd0);
      slow_tick <= (div_r == 10'd0) && (slow_r == 2'd0);
      if (div_r == 10'd0)
      begin
        div_r <= fast_div_w[9:0];
        slow_r <= slow_r + 2'd1;
      end
      else
        div_r <= div_r - 10'd1;
    end
  end

  // Three-sample latency line, then rate-gated outputs.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xd0 <= 24'sh0; xd1 <= 24'sh0; xd2 <= 24'sh0;
      yd0 <= 24'sh0; yd1 <= 24'sh0; yd2 <= 24'sh0;
      x_out <= 24'sh0;
      y_out <= 24'sh0;
      xy_update <= 1'b0;
      rtheta_update <= 1'b0;
    end
    else
    begin
      if (sample_valid)
      begin
        xd0 <= x_sel; xd1 <= xd0; xd2 <= xd1;
        yd0 <= y_sel; yd1 <= yd0; yd2 <= yd1;
      end
      xy_update <= (slope >= 3'd3 && !bypass) ? slow_tick : fast_tick;
      if ((slope >= 3'd3 && !bypass) ? slow_tick : fast_tick)
      begin
        x_out <= xd2;
        y_out <= yd2;
      end
      rtheta_update <= slow_tick;
    end
  end

  // Hundredth-of-tau tick for the settle counter.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tau_cnt_r <= 40'h0;
    else if (settle_start || hundredth)
      tau_cnt_r <= 40'h0;
    else
      tau_cnt_r <= tau_cnt_r + 40'h1;
  end
  assign hundredth = (tau_cnt_r + 40'h1 >= hund_cycles);

  settle_counter u_settle (.pclk(pclk), .presetn(presetn),
    .start(settle_start), .hundredth_tick(hundredth),
    .count(settle_count));

  // Auto sensitivity: one pass of upward steps, then idle.
  assign auto_active = (auto_state_r != AUTO_IDLE);
  // The refusal judges the code written with the request, not the old one.
  assign ev_ref = auto_req &&
                  (clip_tc(pwdata[4:0]) > `TC_1S_CODE);
  assign ev_done = (auto_state_r == AUTO_STEP) &&
                   (sens_r == `SENS_MAX_CODE || magnitude_in[23:22] == 2'b00);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_state_r <= AUTO_IDLE;
      auto_cnt_r <= 14'd0;
      tick_cnt_r <= 7'd0;
      sens_r <= `SENS_RST;
    end
    else
      case (auto_state_r)
        AUTO_IDLE:
        begin
          if (auto_req && !ev_ref)
          begin
            auto_state_r <= AUTO_WAIT;
            sens_r <= 5'd0;
            auto_cnt_r <= 14'd0;
          end
          else if (wr && paddr == `REG_SENS)
            sens_r <= (pwdata[4:0] > `SENS_MAX_CODE) ? `SENS_MAX_CODE :
                      pwdata[4:0];
        end
        AUTO_WAIT:
          if (hundredth)
          begin
            if (auto_cnt_r == `AUTO_STEP_TAUS * 100 - 1)
              auto_state_r <= AUTO_STEP;
            else
              auto_cnt_r <= auto_cnt_r + 14'd1;
          end
        AUTO_STEP:
          if (ev_done)
            auto_state_r <= AUTO_IDLE;
          else
          begin
            sens_r <= sens_r + 5'd1;
            auto_cnt_r <= 14'd0;
            auto_state_r <= AUTO_WAIT;
          end
        default:
          auto_state_r <= AUTO_IDLE;
      endcase
  end

  // Control, sticky interrupt flags (set wins over clear) and mask.
  assign ev_ovf = |ovf_v;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `CTRL_RST;
      irq_stat_r <= 3'b000;
      irq_mask_r <= 3'b000;
      output_filter_overflow_flag <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `REG_CTRL)
        ctrl_r <= {14'h0, 2'b00, 5'h0, pwdata[10:8], 3'h0,
                   clip_tc(pwdata[4:0])};
      if (wr && paddr == `REG_IRQ_MASK)
        irq_mask_r <= pwdata[2:0];
      irq_stat_r <= (irq_stat_r & ~((wr && paddr == `REG_IRQ_STAT) ?
                    pwdata[2:0] : 3'b000)) | {ev_ref, ev_done, ev_ovf};
      output_filter_overflow_flag <= ev_ovf;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data register.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      case (paddr)
        `REG_CTRL: prdata <= ctrl_r;
        `REG_STATUS: prdata <= {28'h0, irq, auto_active, bypass,
                                output_filter_overflow_flag};
        `REG_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
        `REG_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
        `REG_X_OUT: prdata <= {{8{x_out[23]}}, x_out};
        `REG_Y_OUT: prdata <= {{8{y_out[23]}}, y_out};
        `REG_SETTLE: prdata <= {18'h0, settle_count};
        `REG_SENS: prdata <= {27'h0, sens_r};
        default: prdata <= 32'h0000_0000;
      endcase
  end
endmodule // lockin_output_lowpass_filter

// file: lpf_map.vh
`ifndef LPF_MAP_VH
`define LPF_MAP_VH
// Register byte offsets on the APB bus.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_X_OUT 12'h010
`define REG_Y_OUT 12'h014
`define REG_SETTLE 12'h018
`define REG_SENS 12'h01C
// Control register fields.
`define CTRL_TC_LSB 0
`define CTRL_TC_MSB 4
`define CTRL_SLOPE_LSB 8
`define CTRL_SLOPE_MSB 10
`define CTRL_SETTLE_BIT 16
`define CTRL_AUTO_BIT 17
// Reset values.
`define CTRL_RST 32'h0000_0200
`define SENS_RST 5'h00
// Time constant codes: 0 is 100 us, 8 is 1 s, 17 is 30 ks, in 1-3-10 steps.
`define TC_MAX_CODE 5'h11
`define TC_1S_CODE 5'h08
`define SLOPE_BYPASS 3'h5
`define SENS_MAX_CODE 5'h15
// Interrupt bits.
`define IRQ_OVF_BIT 0
`define IRQ_AUTO_DONE_BIT 1
`define IRQ_AUTO_REFUSED_BIT 2
// Timing: sample-rate dividers at 25 MHz.
`define CLK_HZ 25000000
`define FAST_RATE_HZ 96000
`define FAST_DIV (`CLK_HZ / `FAST_RATE_HZ)
`define SLOW_DIV_RATIO 4
`define LATENCY_SAMPLES 3
`define SETTLE_MAX 14'd9999
`define AUTO_STEP_TAUS 5
`endif

// file: lpf_stage.v
`timescale 1ns/1ns
// First-order recursive low-pass stage: y += (x - y) >> shift.
module lpf_stage
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Sample stream.
  input wire step_en,
  input wire [5:0] shift,
  input wire signed [23:0] din,
  output reg signed [23:0] dout,
  // Overflow indication for this stage.
  output reg ovf
);
  wire signed [25:0] diff;
  wire signed [25:0] delta;
  wire signed [25:0] sum;

  // Coefficient is sample period over time constant, a power-of-two shift.
  assign diff = {{2{din[23]}}, din} - {{2{dout[23]}}, dout};
  assign delta = diff >>> shift;
  assign sum = {{2{dout[23]}}, dout} + delta;

  // Update the state once per sample and flag sums that leave range.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout <= 24'sh000000;
      ovf <= 1'b0;
    end
    else if (step_en)
    begin
      ovf <= (sum[25:23] != 3'b000) && (sum[25:23] != 3'b111);
      dout <= sum[23:0];
    end
    else
      ovf <= 1'b0;
  end
endmodule // lpf_stage

// file: settle_counter.v
`timescale 1ns/1ns
`include "lpf_map.vh"
// Counts elapsed time in hundredths of the current time constant.
module settle_counter
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Control.
  input wire start,
  input wire hundredth_tick,
  // Count, 0 to 9999 meaning 0.00 to 99.99 time constants.
  output reg [13:0] count
);
  // Restart on request, advance on each tick, hold at the top.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 14'd0;
    else if (start)
      count <= 14'd0;
    else if (hundredth_tick && count != `SETTLE_MAX)
      count <= count + 14'd1;
  end
endmodule // settle_counter

// file: lpf_src_model.sv
`timescale 1ns/1ns
`include "lpf_map.vh"
// Demodulator model: a sample on each fast tick, big magnitude below thr.
module lpf_src_model
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Test controls.
  input wire signed [23:0] level,
  input wire [4:0] thr,
  input wire [4:0] sensitivity,
  // Samples.
  output reg sample_valid,
  output wire signed [23:0] x_in,
  output wire signed [23:0] y_in,
  output wire signed [23:0] x_if_bypass,
  output wire signed [23:0] y_if_bypass,
  output wire [23:0] magnitude_in
);
  reg [8:0] div_r;
  // The strobe repeats on the fast output grid.
  always @(posedge pclk or negedge presetn)
  if (!presetn)
  begin
    div_r <= 9'h000;
    sample_valid <= 1'b0;
  end
  else
  begin
    div_r <= (div_r == `FAST_DIV - 1) ? 9'h000 : div_r + 9'h001;
    sample_valid <= (div_r == 9'h000);
  end
  // Both paths carry one level; quadrature is its negation.
  assign x_in = level;
  assign y_in = -level;
  assign x_if_bypass = level;
  assign y_if_bypass = -level;
  assign magnitude_in = (sensitivity < thr) ? 24'hC00000 : 24'h001000;
endmodule // lpf_src_model

// file: lpf_props.sv
`timescale 1ns/1ns
`include "lpf_map.vh"
// Watches the bus answer, update strobes and sensitivity handling.
module lpf_props
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Bus.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Outputs watched.
  input wire xy_update,
  input wire rtheta_update,
  input wire if_bypass,
  input wire tc_indicator_on,
  input wire auto_active,
  input wire [4:0] sensitivity
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Cycles since the last magnitude strobe, saturating far above its grid.
  reg [10:0] rt_gap_r;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rt_gap_r <= 11'h000;
    else if (rtheta_update)
      rt_gap_r <= 11'h000;
    else if (rt_gap_r != 11'h7FF)
      rt_gap_r <= rt_gap_r + 11'h001;
  end
  // The bus never stalls and flags only bad accesses.
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_unmapped_err: assert property
    (psel && penable && paddr > `REG_SENS |-> pslverr)
    else $error("unmapped access not flagged");
  // Bypass and the time constant lamp are exclusive.
  chk_bypass_tc: assert property (if_bypass != tc_indicator_on)
    else $error("bypass and tc lamp disagree");
  // Update strobes are single pulses; only the magnitude strobe is also held to its grid.
  chk_xy_pulse: assert property (xy_update |=> !xy_update [*8])
    else $error("xy strobe too close");
  chk_rt_period: assert property (rtheta_update |=>
    !rtheta_update [*8])
    else $error("rtheta strobe too close");
  chk_rt_gap: assert property
    (rt_gap_r < `FAST_DIV * `SLOW_DIV_RATIO)
    else $error("rtheta strobe missing on its grid");
  // Sensitivity moves only by a write or a running search.
  chk_sens_hold: assert property
    (!auto_active && !(psel && penable && pwrite) |=> $stable(sensitivity))
    else $error("sensitivity moved while idle");
  chk_sens_range: assert property (sensitivity <= `SENS_MAX_CODE)
    else $error("sensitivity code too large");
endmodule // lpf_props
bind lockin_output_lowpass_filter lpf_props i_props
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .xy_update(xy_update),
  .rtheta_update(rtheta_update),
  .if_bypass(if_bypass),
  .tc_indicator_on(tc_indicator_on),
  .auto_active(auto_active),
  .sensitivity(sensitivity)
);

// file: lockin_output_lowpass_filter_tb_top.sv
`timescale 1ns/1ns
`include "lpf_map.vh"
// Register-level bench for the output filter block.
module lockin_output_lowpass_filter_tb_top;
  reg pclk, presetn, psel, penable, pwrite, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, q;
  reg signed [23:0] level;
  reg [4:0] thr;
  wire [31:0] prdata;
  wire pready, pslverr, sv, xyu, rtu, byp, tci, ovf, aut, irq;
  wire signed [23:0] xi, yi, xb, yb, xo, yo;
  wire [23:0] mag;
  wire [4:0] sens;
  integer miscompares, n_compared, cyc, nxy, nrt, a, b, i, i0;
  lockin_output_lowpass_filter i_dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sample_valid(sv),
    .x_in(xi),
    .y_in(yi),
    .x_if_bypass(xb),
    .y_if_bypass(yb),
    .magnitude_in(mag),
    .x_out(xo),
    .y_out(yo),
    .xy_update(xyu),
    .rtheta_update(rtu),
    .if_bypass(byp),
    .tc_indicator_on(tci),
    .output_filter_overflow_flag(ovf),
    .auto_active(aut),
    .sensitivity(sens),
    .irq(irq)
  );
  lpf_src_model i_src
  (
    .pclk(pclk),
    .presetn(presetn),
    .level(level),
    .thr(thr),
    .sensitivity(sens),
    .sample_valid(sv),
    .x_in(xi),
    .y_in(yi),
    .x_if_bypass(xb),
    .y_if_bypass(yb),
    .magnitude_in(mag)
  );
  // Clock at 25 MHz.
  always #20 pclk = ~pclk;
  // Strobe counters and the hang limit.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (xyu === 1'b1) nxy <= nxy + 1;
    if (rtu === 1'b1) nrt <= nrt + 1;
    if (cyc == 90000)
    begin
      miscompares = miscompares + 1;
      summarize();
    end
  end
  // One APB transfer; read data and error are taken at the ready edge.
  task xfer(input w, input [11:0] ad, input [31:0] d, output [31:0] r);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  // Compares one value.
  task cmp(input [8*8-1:0] nm, input [31:0] e, input [31:0] s);
  begin
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %0s exp %h got %h", nm, e, s);
    end
  end
  endtask
  // Prints the counts and the verdict.
  task summarize;
  begin
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Main sequence.
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {miscompares, n_compared, cyc, nxy, nrt} = 0;
    level = 24'sd0;
    thr = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, `REG_CTRL, 0, q);
    cmp("ctrl", `CTRL_RST, q);
    cmp("tclamp", 1, tci);
    xfer(0, 12'h020, 0, q);
    cmp("unmap", 32'h1, {31'h0, err});
    cmp("unmapd", 0, q);
    xfer(1, `REG_CTRL, 32'h0000_041F, q);
    xfer(0, `REG_CTRL, 0, q);
    cmp("clip", 32'h0000_0400 | `TC_MAX_CODE, q);
    for (i = 1; i < 5; i = i + 1)
    begin
      xfer(1, `REG_CTRL, i << 8, q);
      repeat (1200) @(posedge pclk);
      a = nxy;
      b = nrt;
      repeat (4160) @(posedge pclk);
      cmp("xyrate", (i < 3) ? 16 : 4, nxy - a);
      cmp("rtrate", 4, nrt - b);
    end
    level <= -24'sd5000;
    xfer(1, `REG_CTRL, 32'h0000_0100, q);
    repeat (15000) @(posedge pclk);
    xfer(0, `REG_X_OUT, 0, q);
    cmp("xfilt", 1, $signed(q) <= -4750 && $signed(q) >= -5250);
    xfer(0, `REG_Y_OUT, 0, q);
    cmp("yfilt", 1, $signed(q) >= 4750 && $signed(q) <= 5250);
    cmp("ovf", 0, ovf);
    level <= 24'sd123456;
    xfer(1, `REG_CTRL, 32'h0000_0500, q);
    repeat (2080) @(posedge pclk);
    cmp("bypass", 1, byp);
    cmp("tcoff", 0, tci);
    xfer(0, `REG_X_OUT, 0, q);
    cmp("xbyp", 32'h0001_E240, q);
    xfer(0, `REG_STATUS, 0, q);
    cmp("stbyp", 2, q & 2);
    xfer(1, `REG_CTRL, 32'h0001_0100, q);
    repeat (250) @(posedge pclk);
    xfer(0, `REG_SETTLE, 0, q);
    cmp("settle", 1, q >= 9 && q <= 11);
    xfer(1, `REG_SENS, 21, q);
    cmp("sens", 21, sens);
    xfer(1, `REG_IRQ_MASK, 0, q);
    xfer(1, `REG_CTRL, 32'h0002_0109, q);
    xfer(0, `REG_IRQ_STAT, 0, q);
    cmp("refuse", 4, q & 4);
    cmp("noauto", 0, aut);
    i0 = irq;
    xfer(1, `REG_IRQ_MASK, 7, q);
    cmp("irqmask", 1, i0 ^ irq);
    xfer(1, `REG_IRQ_STAT, 4, q);
    xfer(0, `REG_IRQ_STAT, 0, q);
    cmp("w1c", 0, q);
    cmp("irqlow", 0, irq);
    thr <= 5'h01;
    xfer(1, `REG_CTRL, 32'h0002_0100, q);
    cmp("autoon", 1, aut);
    for (i = 0; i < 60000 && aut === 1'b1; i = i + 1) @(posedge pclk);
    cmp("autolen", 1, i >= 12000 && i < 60000);
    cmp("autosen", 1, sens);
    xfer(0, `REG_IRQ_STAT, 0, q);
    cmp("autodone", 2, q & 2);
    thr <= 5'h1F;
    repeat (3000) @(posedge pclk);
    cmp("autoidle", 0, aut);
    cmp("senshold", 1, sens);
    summarize();
  end
endmodule // lockin_output_lowpass_filter_tb_top
